// ==== flash_status_pkg.sv ====
package flash_status_pkg;

  localparam int SR_W = 8;
  localparam logic [7:0] SR5_RESET = 8'h00;
  localparam logic [7:0] SR6_RESET = 8'h00;

  localparam int SR5_LOCK_BIT = 7;
  localparam int SR5_DC_MSB = 6;
  localparam int SR5_DC_LSB = 4;
  localparam int SR5_ERASE_HALT_BIT = 3;
  localparam int SR5_PROG_HALT_BIT = 2;
  localparam int SR5_ABORT_EN_BIT = 1;
  localparam int SR5_ALIGN_BIT = 0;

  localparam int SR6_RESULT_MSB = 7;
  localparam int SR6_RESULT_LSB = 6;
  localparam int SR6_THRESH_MSB = 5;
  localparam int SR6_THRESH_LSB = 3;
  localparam int SR6_LOAD_MSB = 2;
  localparam int SR6_LOAD_LSB = 1;
  localparam int SR6_TIME_BIT = 0;

  localparam logic [2:0] DC_CODE_MAX = 3'h4;
  localparam logic [3:0] DC_BASE_CLOCKS = 4'h2;
  localparam logic [3:0] MODE_BYTE_CLOCKS = 4'h2;

  localparam int ADDR_W = 24;
  localparam logic [1:0] ALIGN_LOW_BITS = 2'h0;

  localparam int CLK_FREQ_MHZ = 10;
  localparam int LOAD_SHORT_US = 100;
  localparam int LOAD_LONG_US = 1000;
  localparam int LOAD_SHORT_CYCLES = LOAD_SHORT_US * CLK_FREQ_MHZ;
  localparam int LOAD_LONG_CYCLES = LOAD_LONG_US * CLK_FREQ_MHZ;
  localparam int LOAD_CNT_W = 14;

  typedef enum logic [1:0] {
    RES_IDLE = 2'b00,
    RES_RUNNING = 2'b01,
    RES_ABOVE = 2'b10,
    RES_BELOW = 2'b11
  } battery_result_t;

  typedef enum logic [0:0] {
    BAT_IDLE = 1'b0,
    BAT_LOADING = 1'b1
  } battery_state_t;

endpackage

// ==== level_sync.sv ====
`timescale 1ns/100ps
module level_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  sync_state_t st_r;
  sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.stage1 = asyncIn;
    st_nxt.stage2 = st_r.stage1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign syncOut = st_r.stage2;

endmodule

// ==== load_timer.sv ====
`timescale 1ns/100ps
module load_timer #(
  parameter int CNT_W = flash_status_pkg::LOAD_CNT_W,
  parameter int SHORT_CYCLES = flash_status_pkg::LOAD_SHORT_CYCLES,
  parameter int LONG_CYCLES = flash_status_pkg::LOAD_LONG_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic longSel,
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
  } timer_state_t;

  localparam logic [CNT_W-1:0] SHORT_LAST = CNT_W'(SHORT_CYCLES - 1);
  localparam logic [CNT_W-1:0] LONG_LAST = CNT_W'(LONG_CYCLES - 1);

  timer_state_t st_r;
  timer_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (abort) begin
      st_nxt.busy = 1'b0;
      st_nxt.cnt = '0;
    end else if (start && !st_r.busy) begin
      // Count is reloaded from the selected last value down to zero
      st_nxt.busy = 1'b1;
      st_nxt.cnt = longSel ? LONG_LAST : SHORT_LAST;
    end else if (st_r.busy) begin
      if (st_r.cnt == '0) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.busy;
  assign done = st_r.done;

endmodule

// ==== flash_xip_battery_status_regs.sv ====
`timescale 1ns/100ps
// Function
// - Three-bit code selects 2,4,6,8 or 10 dummy clocks; 101-111 reserved.
// - Dummy total already includes the two mode-byte clocks; host adds none.
// - Read-only erase-halt flag in bit 3 set while erase is suspended.
// - Read-only program-halt flag in bit 2 set while program is suspended.
// - Abort enable changes only by register five write or power cycle.
// - Word-align select forces low two address bits of aligned read to 00.
// - Word-align select affects only the aligned continuous read command.
// - Battery result: 00 idle, 01 running, 10 above, 11 below threshold.
// - Battery status command starts the test and updates the result field.
// - Accepted terminate or an internal condition clears the battery result.
// - Three-bit writable threshold select, 1.8V to 3.2V in 0.2V steps.
// - Two-bit writable load select: 10uA, 100uA, 1mA, 10mA.
// - Load time bit: 0 gives 100 microseconds, 1 gives 1 millisecond.
// - After load time, compare against threshold, result into bits 7:6.
// - All fields, suspend flags and battery result reset to zero.
// - Command-less continuous read only when continuous enable and quad enable.
module flash_xip_battery_status_regs #(
  parameter int LOAD_LONG_CYCLES = flash_status_pkg::LOAD_LONG_CYCLES,
  parameter int LOAD_SHORT_CYCLES = flash_status_pkg::LOAD_SHORT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sr5WriteStb,
  input wire logic sr6WriteStb,
  input wire logic [7:0] writeData,
  input wire logic eraseSuspendEvt,
  input wire logic eraseResumeEvt,
  input wire logic programSuspendEvt,
  input wire logic programResumeEvt,
  input wire logic terminateCmd,
  input wire logic batteryStatusCmd,
  input wire logic batteryInternalClear,
  input wire logic batteryBelowRaw,
  input wire logic quadEnableBit,
  input wire logic continuousReadEnable,
  input wire logic readAddrValid,
  input wire logic [23:0] readAddr,
  input wire logic alignedReadCmd,
  input wire logic quadReadEnd,
  input wire logic modeContinue,
  output logic [7:0] sr5Value,
  output logic [7:0] sr6Value,
  output logic [3:0] dummyClocksTotal,
  output logic [3:0] dummyAfterMode,
  output logic dummyReserved,
  output logic terminateAccept,
  output logic [23:0] effAddr,
  output logic effAddrValid,
  output logic continuousReadActive,
  output logic batteryLoadOn,
  output logic [1:0] batteryLoadSel,
  output logic [2:0] batteryThresholdSel
);

  typedef struct packed {
    logic [2:0] dummyCycleCount;
    logic eraseHaltFlag;
    logic programHaltFlag;
    logic abortCmdEnable;
    logic wordAlignSelect;
    flash_status_pkg::battery_result_t batteryTestResult;
    logic [2:0] batteryThresholdSel;
    logic [1:0] batteryLoadSel;
    logic batteryLoadTime;
    flash_status_pkg::battery_state_t batState;
    logic [3:0] dummyTotal;
    logic [3:0] dummyAfter;
    logic dummyRsvd;
    logic termAccept;
    logic [23:0] addr;
    logic addrValid;
    logic contActive;
    logic loadOn;
  } regs_state_t;

  regs_state_t st_r;
  regs_state_t st_nxt;

  logic batteryBelow;
  logic timerStart;
  logic timerAbort;
  logic timerDone;
  logic termOk;

  level_sync u_below_sync (
    .mclk(mclk),
    .rst(rst),
    .asyncIn(batteryBelowRaw),
    .syncOut(batteryBelow)
  );

  load_timer #(
    .CNT_W(flash_status_pkg::LOAD_CNT_W),
    .SHORT_CYCLES(LOAD_SHORT_CYCLES),
    .LONG_CYCLES(LOAD_LONG_CYCLES)
  ) u_load_timer (
    .mclk(mclk),
    .rst(rst),
    .start(timerStart),
    .abort(timerAbort),
    .longSel(st_r.batteryLoadTime),
    .busy(),
    .done(timerDone)
  );

  // Start only from idle so a repeated status command cannot restart the load
  assign termOk = terminateCmd && st_r.abortCmdEnable;
  // An abort in the same cycle blocks the start, else the state would wait on a timer that never ran
  assign timerStart = batteryStatusCmd && (st_r.batState == flash_status_pkg::BAT_IDLE) && !timerAbort;
  assign timerAbort = termOk || batteryInternalClear;

  always_comb begin
    st_nxt = st_r;
    st_nxt.termAccept = termOk;
    st_nxt.addrValid = 1'b0;

    // Only writable fields are taken from a register write
    if (sr5WriteStb) begin
      st_nxt.dummyCycleCount = writeData[flash_status_pkg::SR5_DC_MSB:flash_status_pkg::SR5_DC_LSB];
      st_nxt.abortCmdEnable = writeData[flash_status_pkg::SR5_ABORT_EN_BIT];
      st_nxt.wordAlignSelect = writeData[flash_status_pkg::SR5_ALIGN_BIT];
    end
    if (sr6WriteStb) begin
      st_nxt.batteryThresholdSel = writeData[flash_status_pkg::SR6_THRESH_MSB:flash_status_pkg::SR6_THRESH_LSB];
      st_nxt.batteryLoadSel = writeData[flash_status_pkg::SR6_LOAD_MSB:flash_status_pkg::SR6_LOAD_LSB];
      st_nxt.batteryLoadTime = writeData[flash_status_pkg::SR6_TIME_BIT];
    end

    // Suspend wins over resume in the same cycle so no event is lost
    if (eraseSuspendEvt) begin
      st_nxt.eraseHaltFlag = 1'b1;
    end else if (eraseResumeEvt) begin
      st_nxt.eraseHaltFlag = 1'b0;
    end
    if (programSuspendEvt) begin
      st_nxt.programHaltFlag = 1'b1;
    end else if (programResumeEvt) begin
      st_nxt.programHaltFlag = 1'b0;
    end

    // Reserved codes fall back to the shortest setting and are flagged
    if (st_r.dummyCycleCount > flash_status_pkg::DC_CODE_MAX) begin
      st_nxt.dummyTotal = flash_status_pkg::DC_BASE_CLOCKS;
      st_nxt.dummyRsvd = 1'b1;
    end else begin
      st_nxt.dummyTotal = {st_r.dummyCycleCount, 1'b0} + flash_status_pkg::DC_BASE_CLOCKS;
      st_nxt.dummyRsvd = 1'b0;
    end
    st_nxt.dummyAfter = st_nxt.dummyTotal - flash_status_pkg::MODE_BYTE_CLOCKS;

    if (readAddrValid) begin
      st_nxt.addrValid = 1'b1;
      if (alignedReadCmd && st_r.wordAlignSelect) begin
        st_nxt.addr = {readAddr[flash_status_pkg::ADDR_W-1:2], flash_status_pkg::ALIGN_LOW_BITS};
      end else begin
        st_nxt.addr = readAddr;
      end
    end

    // Either enable dropping ends the command-less mode at once
    if (!(continuousReadEnable && quadEnableBit)) begin
      st_nxt.contActive = 1'b0;
    end else if (quadReadEnd) begin
      st_nxt.contActive = modeContinue;
    end

    case (st_r.batState)
      flash_status_pkg::BAT_IDLE: begin
        if (timerStart) begin
          st_nxt.batState = flash_status_pkg::BAT_LOADING;
          st_nxt.batteryTestResult = flash_status_pkg::RES_RUNNING;
          st_nxt.loadOn = 1'b1;
        end else if (timerAbort) begin
          st_nxt.batteryTestResult = flash_status_pkg::RES_IDLE;
        end
      end
      flash_status_pkg::BAT_LOADING: begin
        if (timerAbort) begin
          st_nxt.batState = flash_status_pkg::BAT_IDLE;
          st_nxt.batteryTestResult = flash_status_pkg::RES_IDLE;
          st_nxt.loadOn = 1'b0;
        end else if (timerDone) begin
          st_nxt.batState = flash_status_pkg::BAT_IDLE;
          st_nxt.loadOn = 1'b0;
          st_nxt.batteryTestResult = batteryBelow ? flash_status_pkg::RES_BELOW
                                                  : flash_status_pkg::RES_ABOVE;
        end
      end
      default: begin
        st_nxt.batState = flash_status_pkg::BAT_IDLE;
        st_nxt.loadOn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.dummyTotal <= flash_status_pkg::DC_BASE_CLOCKS;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Lock bit is outside this block and reads as zero
  assign sr5Value = {1'b0, st_r.dummyCycleCount, st_r.eraseHaltFlag, st_r.programHaltFlag,
                     st_r.abortCmdEnable, st_r.wordAlignSelect};
  assign sr6Value = {st_r.batteryTestResult, st_r.batteryThresholdSel, st_r.batteryLoadSel,
                     st_r.batteryLoadTime};
  assign dummyClocksTotal = st_r.dummyTotal;
  assign dummyAfterMode = st_r.dummyAfter;
  assign dummyReserved = st_r.dummyRsvd;
  assign terminateAccept = st_r.termAccept;
  assign effAddr = st_r.addr;
  assign effAddrValid = st_r.addrValid;
  assign continuousReadActive = st_r.contActive;
  assign batteryLoadOn = st_r.loadOn;
  assign batteryLoadSel = st_r.batteryLoadSel;
  assign batteryThresholdSel = st_r.batteryThresholdSel;

endmodule

// ==== host_model.sv ====
`timescale 1ns/100ps
module host_model (
  input wire logic mclk,
  input wire logic [2:0] op,
  input wire logic [7:0] dIn,
  output logic sr5WriteStb,
  output logic sr6WriteStb,
  output logic terminateCmd,
  output logic batteryStatusCmd,
  output logic [7:0] writeData
);
  initial {sr5WriteStb, sr6WriteStb, terminateCmd, batteryStatusCmd, writeData} = 12'h000;
  // Op 1/2 write a register, 3 terminate, 4 battery status; one-cycle strobes
  always @(posedge mclk) begin
    sr5WriteStb <= op == 3'h1;
    sr6WriteStb <= op == 3'h2;
    terminateCmd <= op == 3'h3;
    batteryStatusCmd <= op == 3'h4;
    // Idle bus inverts every cycle, so the stale byte shows only on alternate cycles
    writeData <= (op == 3'h1 || op == 3'h2) ? dIn : ~writeData;
  end
endmodule

// ==== status_regs_asserts.sv ====
`timescale 1ns/100ps
module status_regs_asserts #(
  parameter int LOAD_LONG_CYCLES = 10000,
  parameter int LOAD_SHORT_CYCLES = 1000
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sr5WriteStb,
  input wire logic [7:0] writeData,
  input wire logic terminateCmd,
  input wire logic batteryStatusCmd,
  input wire logic batteryInternalClear,
  input wire logic readAddrValid,
  input wire logic [23:0] readAddr,
  input wire logic alignedReadCmd,
  input wire logic [7:0] sr5Value,
  input wire logic [7:0] sr6Value,
  input wire logic [3:0] dummyClocksTotal,
  input wire logic [3:0] dummyAfterMode,
  input wire logic terminateAccept,
  input wire logic [23:0] effAddr,
  input wire logic effAddrValid,
  input wire logic batteryLoadOn
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  int loadCnt_r;
  int loadCnt_nxt;
  logic [7:0] wdPrev_r;
  logic [23:0] addrPrev_r;
  always_comb loadCnt_nxt = batteryLoadOn ? loadCnt_r + 1 : 0;
  // One-cycle-old copies, so no property needs the past value of a slice
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      loadCnt_r <= 0;
      wdPrev_r <= 8'h00;
      addrPrev_r <= 24'h000000;
    end else begin
      loadCnt_r <= loadCnt_nxt;
      wdPrev_r <= writeData;
      addrPrev_r <= readAddr;
    end
  end
  property p_wr5;
    sr5WriteStb |=> {sr5Value[6:4], sr5Value[1:0]} == {wdPrev_r[6:4], wdPrev_r[1:0]};
  endproperty
  a_wr5: assert property (p_wr5) else $error("write lost");
  property p_hold; !sr5WriteStb |=> $stable(sr5Value[1]); endproperty
  a_hold: assert property (p_hold) else $error("abort enable moved");
  property p_term;
    terminateCmd && sr5Value[1] |=> terminateAccept && sr6Value[7:6] == 2'b00;
  endproperty
  a_term: assert property (p_term) else $error("terminate lost");
  property p_after; dummyAfterMode == dummyClocksTotal - 4'h2; endproperty
  a_after: assert property (p_after) else $error("mode clocks");
  property p_align;
    readAddrValid && alignedReadCmd && sr5Value[0] |=> effAddrValid && effAddr == {addrPrev_r[23:2], 2'b00};
  endproperty
  a_align: assert property (p_align) else $error("align");
  property p_full;
    readAddrValid && !alignedReadCmd |=> effAddrValid && effAddr == addrPrev_r;
  endproperty
  a_full: assert property (p_full) else $error("full address");
  property p_start;
    batteryStatusCmd && !batteryLoadOn && !terminateCmd && !batteryInternalClear |=> batteryLoadOn && sr6Value[7:6] == 2'b01;
  endproperty
  a_start: assert property (p_start) else $error("test start");
  property p_len;
    $fell(batteryLoadOn) && sr6Value[7] |-> loadCnt_r == (sr6Value[0] ? LOAD_LONG_CYCLES : LOAD_SHORT_CYCLES) + 1;
  endproperty
  a_len: assert property (p_len) else $error("load time");
  c_done: cover property ($fell(batteryLoadOn) && sr6Value[7]);
  c_term: cover property (terminateAccept);
  c_align: cover property (effAddrValid && sr5Value[0]);
endmodule
bind flash_xip_battery_status_regs status_regs_asserts #(
  .LOAD_LONG_CYCLES(LOAD_LONG_CYCLES),
  .LOAD_SHORT_CYCLES(LOAD_SHORT_CYCLES)
) chk (
  .mclk(mclk),
  .rst(rst),
  .sr5WriteStb(sr5WriteStb),
  .writeData(writeData),
  .terminateCmd(terminateCmd),
  .batteryStatusCmd(batteryStatusCmd),
  .batteryInternalClear(batteryInternalClear),
  .readAddrValid(readAddrValid),
  .readAddr(readAddr),
  .alignedReadCmd(alignedReadCmd),
  .sr5Value(sr5Value),
  .sr6Value(sr6Value),
  .dummyClocksTotal(dummyClocksTotal),
  .dummyAfterMode(dummyAfterMode),
  .terminateAccept(terminateAccept),
  .effAddr(effAddr),
  .effAddrValid(effAddrValid),
  .batteryLoadOn(batteryLoadOn)
);

// ==== tb.sv ====
`timescale 1ns/100ps
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin n_errors++; $display("[ERR] %0t mismatch got %h exp %h", $time, g, w); end end
module tb;
  logic mclk = 0, rst = 1, sr5WriteStb, sr6WriteStb, terminateCmd, batteryStatusCmd, eraseResumeEvt = 0;
  logic eraseSuspendEvt = 0, programSuspendEvt = 0, programResumeEvt = 0, batteryInternalClear = 0;
  logic batteryBelowRaw = 0, quadEnableBit = 1, continuousReadEnable = 0, readAddrValid = 0, alignedReadCmd = 0;
  logic quadReadEnd = 0, modeContinue = 0, dummyReserved, terminateAccept, effAddrValid, continuousReadActive;
  logic batteryLoadOn;
  logic [7:0] writeData, sr5Value, sr6Value, dIn = 0;
  logic [23:0] readAddr = 0, effAddr, a, e, expQ[$];
  logic [3:0] dummyClocksTotal, dummyAfterMode;
  logic [2:0] op = 0, thr, batteryThresholdSel;
  logic [1:0] ld, batteryLoadSel;
  int n_errors = 0, n_compared = 0, cyc = 0;
  host_model host (
    .mclk(mclk),
    .op(op),
    .dIn(dIn),
    .sr5WriteStb(sr5WriteStb),
    .sr6WriteStb(sr6WriteStb),
    .terminateCmd(terminateCmd),
    .batteryStatusCmd(batteryStatusCmd),
    .writeData(writeData)
  );
  flash_xip_battery_status_regs #(.LOAD_LONG_CYCLES(20), .LOAD_SHORT_CYCLES(8)) dut (
    .mclk(mclk),
    .rst(rst),
    .sr5WriteStb(sr5WriteStb),
    .sr6WriteStb(sr6WriteStb),
    .writeData(writeData),
    .eraseSuspendEvt(eraseSuspendEvt),
    .eraseResumeEvt(eraseResumeEvt),
    .programSuspendEvt(programSuspendEvt),
    .programResumeEvt(programResumeEvt),
    .terminateCmd(terminateCmd),
    .batteryStatusCmd(batteryStatusCmd),
    .batteryInternalClear(batteryInternalClear),
    .batteryBelowRaw(batteryBelowRaw),
    .quadEnableBit(quadEnableBit),
    .continuousReadEnable(continuousReadEnable),
    .readAddrValid(readAddrValid),
    .readAddr(readAddr),
    .alignedReadCmd(alignedReadCmd),
    .quadReadEnd(quadReadEnd),
    .modeContinue(modeContinue),
    .sr5Value(sr5Value),
    .sr6Value(sr6Value),
    .dummyClocksTotal(dummyClocksTotal),
    .dummyAfterMode(dummyAfterMode),
    .dummyReserved(dummyReserved),
    .terminateAccept(terminateAccept),
    .effAddr(effAddr),
    .effAddrValid(effAddrValid),
    .continuousReadActive(continuousReadActive),
    .batteryLoadOn(batteryLoadOn),
    .batteryLoadSel(batteryLoadSel),
    .batteryThresholdSel(batteryThresholdSel)
  );
  initial forever #50 mclk = ~mclk;
  task automatic cmd(input logic [2:0] o, input logic [7:0] d);
    @(posedge mclk);
    op <= o;
    dIn <= d;
    @(posedge mclk);
    op <= 3'h0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic wait_idle();
    repeat (40) if (batteryLoadOn === 1'b1) @(negedge mclk);
    `CHK(batteryLoadOn, 1'b0)
  endtask
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  always @(negedge mclk) if (effAddrValid === 1'b1) begin
    e = expQ.pop_front();
    `CHK(effAddr, e)
  end
  initial begin
    void'($urandom(32'h638c));
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK({sr5Value, sr6Value, dummyClocksTotal, dummyAfterMode}, 24'h000020)
    for (int i = 0; i < 8; i++) begin
      cmd(3'h1, {1'b1, 3'(i), 4'hC});
      `CHK(sr5Value, {1'b0, 3'(i), 4'h0})
      @(negedge mclk);
      `CHK({dummyReserved, dummyClocksTotal, dummyAfterMode}, (i < 5) ? {1'b0, 4'(2 * i + 2), 4'(2 * i)} : 9'h120)
    end
    @(posedge mclk);
    eraseSuspendEvt <= 1'b1;
    programSuspendEvt <= 1'b1;
    @(posedge mclk);
    eraseSuspendEvt <= 1'b0;
    programSuspendEvt <= 1'b0;
    @(negedge mclk);
    `CHK(sr5Value[3:2], 2'b11)
    // Resume clears; suspend and resume together keep the flag set
    @(posedge mclk);
    eraseResumeEvt <= 1'b1;
    programSuspendEvt <= 1'b1;
    programResumeEvt <= 1'b1;
    @(posedge mclk);
    eraseResumeEvt <= 1'b0;
    programSuspendEvt <= 1'b0;
    programResumeEvt <= 1'b0;
    @(negedge mclk);
    `CHK(sr5Value[3:2], 2'b01)
    cmd(3'h1, 8'h02);
    `CHK(sr5Value, 8'h06)
    thr = 3'($urandom);
    ld = 2'($urandom);
    cmd(3'h2, {2'b11, thr, ld, 1'b0});
    `CHK({sr6Value, batteryThresholdSel, batteryLoadSel}, {2'b00, thr, ld, 1'b0, thr, ld})
    cmd(3'h4, 8'h00);
    `CHK({sr6Value[7:6], batteryLoadOn}, 3'b011)
    cmd(3'h3, 8'h00);
    `CHK({sr6Value[7:6], batteryLoadOn, terminateAccept}, 4'b0001)
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      batteryBelowRaw <= i[0];
      cmd(3'h2, {2'b00, thr, ld, i[1]});
      cmd(3'h4, 8'h00);
      wait_idle();
      `CHK(sr6Value[7:6], {1'b1, i[0]})
    end
    cmd(3'h1, 8'h00);
    cmd(3'h4, 8'h00);
    cmd(3'h3, 8'h00);
    `CHK({sr6Value[7:6], terminateAccept}, 3'b010)
    wait_idle();
    // Status command and internal clear on one edge: clear wins, no test starts
    @(posedge mclk);
    op <= 3'h4;
    @(posedge mclk);
    op <= 3'h0;
    batteryInternalClear <= 1'b1;
    @(posedge mclk);
    batteryInternalClear <= 1'b0;
    @(negedge mclk);
    `CHK({sr6Value[7:6], batteryLoadOn}, 3'b000)
    cmd(3'h4, 8'h00);
    `CHK({sr6Value[7:6], batteryLoadOn}, 3'b011)
    wait_idle();
    for (int w = 0; w < 2; w++) begin
      cmd(3'h1, 8'(w));
      for (int i = 0; i < 6; i++) begin
        a = 24'($urandom);
        @(posedge mclk);
        readAddrValid <= 1'b1;
        readAddr <= a;
        alignedReadCmd <= i[0];
        expQ.push_back((i[0] && w == 1) ? {a[23:2], 2'b00} : a);
      end
      @(posedge mclk);
      readAddrValid <= 1'b0;
    end
    @(posedge mclk);
    continuousReadEnable <= 1'b1;
    quadEnableBit <= 1'b0;
    quadReadEnd <= 1'b1;
    modeContinue <= 1'b1;
    @(posedge mclk);
    quadEnableBit <= 1'b1;
    @(negedge mclk);
    `CHK(continuousReadActive, 1'b0)
    @(posedge mclk);
    quadReadEnd <= 1'b0;
    @(negedge mclk);
    `CHK(continuousReadActive, 1'b1)
    @(posedge mclk);
    quadReadEnd <= 1'b1;
    modeContinue <= 1'b0;
    @(posedge mclk);
    quadReadEnd <= 1'b0;
    @(negedge mclk);
    `CHK(continuousReadActive, 1'b0)
    @(posedge mclk);
    quadReadEnd <= 1'b1;
    modeContinue <= 1'b1;
    @(posedge mclk);
    quadReadEnd <= 1'b0;
    continuousReadEnable <= 1'b0;
    @(negedge mclk);
    `CHK(continuousReadActive, 1'b1)
    @(negedge mclk);
    `CHK({continuousReadActive, 32'(expQ.size())}, 33'h0)
    close_out();
  end
endmodule
